// >>> inc/ivmm_defines.svh
// constants of the interrupt vector and memory map block
// assumes nothing; included by bare name wherever a figure is needed
`ifndef IVMM_DEFINES_SVH
`define IVMM_DEFINES_SVH

// program store layout
`define ROM_WORDS 4096
`define ROM_WORD_W 12
`define ROM_PAGES 16
`define ROM_STEPS 256
`define RESET_PAGE 4'h1
`define RESET_STEP 8'h00

// vector table
`define NUM_SRC 7
`define VEC_PAGE 4'h1
`define VEC_STEP_BASE 8'h02
`define VEC_STEP_STRIDE 8'h02
`define SRC_CLOCK_TIMER 3'h0
`define SRC_STOPWATCH 3'h1
`define SRC_AD_CONV 3'h2
`define SRC_KEY_GROUP 3'h3
`define SRC_SINGLE_KEY 3'h4
`define SRC_SERIAL 3'h5
`define SRC_PROG_TIMER 3'h6

// data space layout
`define RAM_WORDS 512
`define ROW_DISP_FIRST 4'h8
`define ROW_DISP_LAST 4'h9
`define ROW_IO_FIRST 4'hc
`define IO_WORDS 6'h38
`define MREG_BASE 6'h00

// stack
`define STACK_WORDS 9'h003
`define SP_STEP 9'h001
`define SP_RESET 9'h000

`define DATA_ZERO 4'h0

`endif

// >>> inc/ivmm_pkg.sv
// types shared by the interrupt vector and memory map block
// assumes ivmm_defines.svh for figures
package ivmm_pkg;
	typedef logic [3:0] nibble_t;
	typedef logic [3:0] page_t;
	typedef logic [7:0] step_t;
	typedef logic [9:0] data_addr_t;
	typedef logic [8:0] ram_idx_t;
	typedef logic [6:0] src_vec_t;
	typedef enum logic [1:0] {REGION_RAM, REGION_DISPLAY, REGION_IO, REGION_UNUSED} region_t;
	typedef enum logic [2:0] {PUSH_IDLE, PUSH_PAGE, PUSH_STEP_HI, PUSH_STEP_LO, PUSH_LOAD} push_state_t;
endpackage

// >>> core/vector_priority.sv
// fixed-priority resolver: highest vector address among allowed requests
// assumes request lines come from logic on the same clock
`timescale 1ns/1ps
`include "ivmm_defines.svh"
module vector_priority
	import ivmm_pkg::*;
(
	input wire src_vec_t i_req,
	input wire src_vec_t i_allow,
	output logic o_valid,
	output logic [2:0] o_src,
	output step_t o_step
);
	function automatic step_t vector_step(input logic [2:0] src);
		vector_step = step_t'(`VEC_STEP_BASE + `VEC_STEP_STRIDE * step_t'(src));
	endfunction

	always_comb begin
		o_valid = 1'b0;
		o_src = 3'h0;
		// later index overrides, so the highest address wins
		for (int i = 0; i < `NUM_SRC; i++) begin
			if (i_req[i] && i_allow[i]) begin
				o_valid = 1'b1;
				o_src = 3'(i);
			end
		end
		o_step = vector_step(o_src);
	end
endmodule

// >>> core/data_decode.sv
// data address decode into ram, display, i/o and unused space
// assumes a 10-bit address: page[9:8], row[7:4], column[3:0]
`timescale 1ns/1ps
`include "ivmm_defines.svh"
module data_decode
	import ivmm_pkg::*;
(
	input wire data_addr_t i_addr,
	output region_t o_region,
	output ram_idx_t o_ram_idx
);
	logic [3:0] row;
	logic [5:0] io_off;

	always_comb begin
		row = i_addr[7:4];
		io_off = {row[1:0], i_addr[3:0]};
		o_ram_idx = {i_addr[9:8], row[2:0], i_addr[3:0]};
		if (row < `ROW_DISP_FIRST) begin
			o_region = REGION_RAM;
		end else if (row <= `ROW_DISP_LAST) begin
			o_region = REGION_DISPLAY;
		end else if (row >= `ROW_IO_FIRST && io_off < `IO_WORDS) begin
			o_region = REGION_IO;
		end else begin
			o_region = REGION_UNUSED;
		end
	end
endmodule

// >>> core/interrupt_vector_and_memory_map.sv
// interrupt vectoring, sleep wake, stack push and data space decode
// assumes requests and cpu strobes come from logic on i_ref_clk
//
// Summary of operation
// RL1 - after reset the program counter is loaded with page 1, step 00
// RL2 - program store is 4096 words of 12 bits, 16 pages of 256 steps
// RL3 - all interrupt entry addresses sit in page 1, steps 02 to 0f
// RL4 - each source has its own vector, clock timer 102 up to programmable timer 10e
// RL5 - simultaneous requests: only the highest vector address is loaded
// RL6 - sleep ends only on single key interrupt or reset
// RL7 - a call or interrupt entry pushes three 4-bit words into data ram
// RL8 - ram words 000 to 00f also reachable through the memory register pointer
// RL9 - data memory is 512 words of ram plus an i/o region
// RL10 - rows 8 and 9 of each page are write-only display memory, 32 words
// RL11 - rows from c upward decode as 56 words of i/o memory
// RL12 - software must not access unused data addresses
// RL13 - requests sampled at instruction boundary; vector held during the push
`timescale 1ns/1ps
`include "ivmm_defines.svh"
module interrupt_vector_and_memory_map
	import ivmm_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire src_vec_t i_req,
	input wire logic i_int_enable,
	input wire logic i_boundary,
	input wire logic i_sleep_req,
	input wire logic i_call,
	input wire logic i_pop,
	input wire page_t i_ret_page,
	input wire step_t i_ret_step,
	input wire data_addr_t i_addr,
	input wire logic i_mreg_acc,
	input wire logic i_we,
	input wire logic i_re,
	input wire nibble_t i_wdata,
	input wire logic i_mreg_ptr_we,
	input wire nibble_t i_io_rdata,
	output logic o_pc_load,
	output page_t o_program_page_counter,
	output step_t o_program_step_counter,
	output src_vec_t o_ack,
	output logic o_vec_hold,
	output logic o_busy,
	output logic o_sleeping,
	output ram_idx_t o_stack_pointer,
	output nibble_t o_memory_register_pointer,
	output nibble_t o_rd_data,
	output logic o_rd_valid,
	output logic o_disp_we,
	output data_addr_t o_disp_addr,
	output nibble_t o_disp_wdata,
	output logic o_io_we,
	output logic o_io_re,
	output data_addr_t o_io_addr,
	output nibble_t o_io_wdata
);
	// resolver
	src_vec_t allow;
	logic pend_valid;
	logic [2:0] pend_src;
	step_t pend_step;

	// sleep group
	logic sleep_r, sleep_nxt;

	// entry and stack group
	push_state_t state_r, state_nxt;
	logic boot_r, boot_nxt;
	logic is_irq_r, is_irq_nxt;
	step_t vec_step_r, vec_step_nxt;
	page_t ret_page_r, ret_page_nxt;
	step_t ret_step_r, ret_step_nxt;
	ram_idx_t sp_r, sp_nxt;
	logic pc_load_r, pc_load_nxt;
	page_t pc_page_r, pc_page_nxt;
	step_t pc_step_r, pc_step_nxt;
	src_vec_t ack_r, ack_nxt;
	logic busy_r, busy_nxt;
	logic hold_r, hold_nxt;

	// data access group
	nibble_t ram [`RAM_WORDS];
	logic ram_we;
	ram_idx_t ram_widx;
	nibble_t ram_wdata;
	data_addr_t eff_addr;
	region_t region;
	ram_idx_t cpu_idx;
	nibble_t mptr_r, mptr_nxt;
	nibble_t rd_data_r, rd_data_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic io_pend_r, io_pend_nxt;
	logic disp_we_r, disp_we_nxt;
	data_addr_t disp_addr_r, disp_addr_nxt;
	nibble_t disp_wdata_r, disp_wdata_nxt;
	logic io_we_r, io_we_nxt;
	logic io_re_r, io_re_nxt;
	data_addr_t io_addr_r, io_addr_nxt;
	nibble_t io_wdata_r, io_wdata_nxt;

	function automatic src_vec_t one_hot(input logic [2:0] src);
		one_hot = src_vec_t'(7'h01 << src);
	endfunction

	always_comb begin
		// asleep, only the single key input may be serviced
		allow = sleep_r ? one_hot(`SRC_SINGLE_KEY) : '1; // see RL6
	end

	vector_priority u_prio (
		.i_req(i_req),
		.i_allow(allow),
		.o_valid(pend_valid),
		.o_src(pend_src),
		.o_step(pend_step)
	);

	// sleep flag
	always_comb begin
		sleep_nxt = sleep_r;
		if (i_req[`SRC_SINGLE_KEY]) begin
			sleep_nxt = 1'b0; // see RL6
		end else if (i_sleep_req) begin
			sleep_nxt = 1'b1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sleep_r <= 1'b0; // see RL6
		end else begin
			sleep_r <= sleep_nxt;
		end
	end

	// interrupt entry and stack push
	always_comb begin
		state_nxt = state_r;
		boot_nxt = 1'b0;
		is_irq_nxt = is_irq_r;
		vec_step_nxt = vec_step_r;
		ret_page_nxt = ret_page_r;
		ret_step_nxt = ret_step_r;
		sp_nxt = sp_r;
		pc_load_nxt = 1'b0;
		pc_page_nxt = pc_page_r;
		pc_step_nxt = pc_step_r;
		ack_nxt = '0;
		ram_we = 1'b0;
		ram_widx = sp_r - `SP_STEP;
		ram_wdata = `DATA_ZERO;
		unique case (state_r)
			PUSH_IDLE: begin
				if (boot_r) begin
					pc_load_nxt = 1'b1; // see RL1
				end else if (i_boundary && i_int_enable && pend_valid) begin
					// sampled only at the boundary, then frozen
					is_irq_nxt = 1'b1; // see RL13
					vec_step_nxt = pend_step; // see RL5
					ack_nxt = one_hot(pend_src);
					ret_page_nxt = i_ret_page;
					ret_step_nxt = i_ret_step;
					state_nxt = PUSH_PAGE;
				end else if (i_call) begin
					is_irq_nxt = 1'b0;
					ret_page_nxt = i_ret_page;
					ret_step_nxt = i_ret_step;
					state_nxt = PUSH_PAGE;
				end else if (i_pop) begin
					sp_nxt = sp_r + `STACK_WORDS; // see RL7
				end
			end
			PUSH_PAGE: begin
				ram_we = 1'b1; // see RL7
				ram_wdata = ret_page_r;
				sp_nxt = sp_r - `SP_STEP;
				state_nxt = PUSH_STEP_HI;
			end
			PUSH_STEP_HI: begin
				ram_we = 1'b1; // see RL7
				ram_wdata = ret_step_r[7:4];
				sp_nxt = sp_r - `SP_STEP;
				state_nxt = PUSH_STEP_LO;
			end
			PUSH_STEP_LO: begin
				ram_we = 1'b1; // see RL7
				ram_wdata = ret_step_r[3:0];
				sp_nxt = sp_r - `SP_STEP;
				state_nxt = PUSH_LOAD;
			end
			PUSH_LOAD: begin
				if (is_irq_r) begin
					pc_load_nxt = 1'b1;
					pc_page_nxt = `VEC_PAGE; // see RL3
					pc_step_nxt = vec_step_r; // see RL4
				end
				state_nxt = PUSH_IDLE;
			end
		endcase
		busy_nxt = state_nxt != PUSH_IDLE;
		hold_nxt = busy_nxt && is_irq_nxt; // see RL13
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_r <= PUSH_IDLE;
			boot_r <= 1'b1;
			is_irq_r <= 1'b0;
			vec_step_r <= `VEC_STEP_BASE;
			ret_page_r <= `RESET_PAGE;
			ret_step_r <= `RESET_STEP;
			sp_r <= `SP_RESET;
			pc_load_r <= 1'b0;
			pc_page_r <= `RESET_PAGE; // see RL1
			pc_step_r <= `RESET_STEP; // see RL1
			ack_r <= '0;
			busy_r <= 1'b0;
			hold_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			boot_r <= boot_nxt;
			is_irq_r <= is_irq_nxt;
			vec_step_r <= vec_step_nxt;
			ret_page_r <= ret_page_nxt;
			ret_step_r <= ret_step_nxt;
			sp_r <= sp_nxt;
			pc_load_r <= pc_load_nxt;
			pc_page_r <= pc_page_nxt;
			pc_step_r <= pc_step_nxt;
			ack_r <= ack_nxt;
			busy_r <= busy_nxt;
			hold_r <= hold_nxt;
		end
	end

	// cpu data access
	always_comb begin
		// memory registers are the first sixteen ram words
		eff_addr = i_mreg_acc ? {`MREG_BASE, mptr_r} : i_addr; // see RL8
	end

	data_decode u_decode (
		.i_addr(eff_addr),
		.o_region(region),
		.o_ram_idx(cpu_idx)
	);

	always_comb begin
		mptr_nxt = i_mreg_ptr_we ? i_wdata : mptr_r;
		rd_valid_nxt = 1'b0;
		rd_data_nxt = rd_data_r;
		io_pend_nxt = 1'b0;
		disp_we_nxt = 1'b0;
		disp_addr_nxt = disp_addr_r;
		disp_wdata_nxt = disp_wdata_r;
		io_we_nxt = 1'b0;
		io_re_nxt = 1'b0;
		io_addr_nxt = io_addr_r;
		io_wdata_nxt = io_wdata_r;
		if (io_pend_r) begin
			rd_data_nxt = i_io_rdata;
			rd_valid_nxt = 1'b1;
		end
		// cpu strobes are ignored while the stack is being written
		if (!busy_r && (i_we || i_re)) begin
			unique case (region)
				REGION_RAM: begin
					if (i_re) begin
						rd_data_nxt = ram[cpu_idx]; // see RL9
						rd_valid_nxt = 1'b1;
					end
				end
				REGION_DISPLAY: begin
					disp_we_nxt = i_we; // see RL10
					disp_addr_nxt = eff_addr;
					disp_wdata_nxt = i_wdata;
					if (i_re) begin
						rd_data_nxt = `DATA_ZERO; // see RL10
						rd_valid_nxt = 1'b1;
					end
				end
				REGION_IO: begin
					io_we_nxt = i_we; // see RL11
					io_re_nxt = i_re && !i_we;
					io_addr_nxt = eff_addr;
					io_wdata_nxt = i_wdata;
					io_pend_nxt = i_re && !i_we;
				end
				REGION_UNUSED: begin
					// nothing stored; reads return zero
					if (i_re) begin
						rd_data_nxt = `DATA_ZERO; // see RL12
						rd_valid_nxt = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			mptr_r <= `DATA_ZERO;
			rd_data_r <= `DATA_ZERO;
			rd_valid_r <= 1'b0;
			io_pend_r <= 1'b0;
			disp_we_r <= 1'b0;
			disp_addr_r <= '0;
			disp_wdata_r <= `DATA_ZERO;
			io_we_r <= 1'b0;
			io_re_r <= 1'b0;
			io_addr_r <= '0;
			io_wdata_r <= `DATA_ZERO;
		end else begin
			mptr_r <= mptr_nxt;
			rd_data_r <= rd_data_nxt;
			rd_valid_r <= rd_valid_nxt;
			io_pend_r <= io_pend_nxt;
			disp_we_r <= disp_we_nxt;
			disp_addr_r <= disp_addr_nxt;
			disp_wdata_r <= disp_wdata_nxt;
			io_we_r <= io_we_nxt;
			io_re_r <= io_re_nxt;
			io_addr_r <= io_addr_nxt;
			io_wdata_r <= io_wdata_nxt;
		end
	end

	// ram has no reset; stack writes win over the cpu
	always_ff @(posedge i_ref_clk) begin
		if (ram_we) begin
			ram[ram_widx] <= ram_wdata; // see RL7
		end else if (!busy_r && i_we && region == REGION_RAM) begin
			ram[cpu_idx] <= i_wdata; // see RL9
		end
	end

	// registered outputs
	always_comb begin
		o_pc_load = pc_load_r;
		o_program_page_counter = pc_page_r; // see RL2
		o_program_step_counter = pc_step_r; // see RL2
		o_ack = ack_r;
		o_vec_hold = hold_r;
		o_busy = busy_r;
		o_sleeping = sleep_r;
		o_stack_pointer = sp_r;
		o_memory_register_pointer = mptr_r;
		o_rd_data = rd_data_r;
		o_rd_valid = rd_valid_r;
		o_disp_we = disp_we_r;
		o_disp_addr = disp_addr_r;
		o_disp_wdata = disp_wdata_r;
		o_io_we = io_we_r;
		o_io_re = io_re_r;
		o_io_addr = io_addr_r;
		o_io_wdata = io_wdata_r;
	end
endmodule

// >>> test/io_peer.sv
// far-side i/o peripheral model answering the block's i/o reads
// assumes i/o strobes come on i_ref_clk
`timescale 1ns/1ps
module io_peer
	import ivmm_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_io_re,
	input wire data_addr_t i_io_addr,
	output nibble_t o_io_rdata
);
	nibble_t junk_r = 4'h0;
	always @(posedge i_ref_clk) begin
		junk_r <= junk_r + 4'h5;
	end
	// valid only while read strobe is up, changing junk otherwise
	assign o_io_rdata = i_io_re ? (i_io_addr[3:0] ^ i_io_addr[7:4]) : junk_r;
endmodule

// >>> test/ivmm_chk.sv
// checker: vectoring, sleep, stack and decode timing at the ports
// assumes the top module ports, one clock domain
`timescale 1ns/1ps
module ivmm_chk
	import ivmm_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire src_vec_t i_req,
	input wire logic i_int_enable,
	input wire logic i_boundary,
	input wire logic i_re,
	input wire logic i_we,
	input wire data_addr_t i_addr,
	input wire logic i_mreg_acc,
	input wire logic o_pc_load,
	input wire page_t o_program_page_counter,
	input wire step_t o_program_step_counter,
	input wire src_vec_t o_ack,
	input wire logic o_vec_hold,
	input wire logic o_busy,
	input wire logic o_sleeping,
	input wire ram_idx_t o_stack_pointer,
	input wire nibble_t o_rd_data,
	input wire logic o_rd_valid,
	input wire logic o_io_re,
	input wire data_addr_t o_io_addr
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_b);
	function automatic src_vec_t top_req(input src_vec_t q);
		top_req = 7'h00;
		for (int k = 0; k < 7; k++)
			if (q[k]) top_req = 7'h01 << k;
	endfunction
	function automatic step_t vec_of(input src_vec_t q);
		vec_of = 8'h00;
		for (int k = 0; k < 7; k++)
			if (q[k]) vec_of = 8'h02 + 8'(2 * k);
	endfunction
	sequence hold_run;
		o_vec_hold [*4] ##1 (!o_vec_hold && o_pc_load);
	endsequence
	sequence disp_take;
		i_re && !i_we && !o_busy && !i_mreg_acc && i_addr[7:5] == 3'h4;
	endsequence
	sequence io_take;
		i_re && !i_we && !o_busy && !i_mreg_acc && i_addr[7:6] == 2'h3 && i_addr[5:0] < 6'h38;
	endsequence
	boot_start_a: assert property (o_pc_load && !$past(o_vec_hold) |->
		o_program_page_counter == 4'h1 && o_program_step_counter == 8'h00) else $error("bad boot address");
	vec_page_a: assert property (o_pc_load |-> o_program_page_counter == 4'h1) else $error("vector page wrong");
	vec_step_a: assert property ($past(o_ack, 4) != 7'h00 |->
		o_pc_load && o_program_step_counter == vec_of($past(o_ack, 4))) else $error("vector step wrong");
	prio_win_a: assert property (o_ack != 7'h00 && !$past(o_sleeping) |->
		$past(i_boundary && i_int_enable) && o_ack == top_req($past(i_req))) else $error("wrong winner");
	hold_len_a: assert property ($rose(o_vec_hold) |-> hold_run) else $error("vector hold length");
	stack_push_a: assert property ($rose(o_busy) |->
		##4 o_stack_pointer == $past(o_stack_pointer, 5) - 9'h003) else $error("push not three words");
	sleep_wake_a: assert property (o_sleeping |=> o_sleeping == !$past(i_req[4])) else $error("sleep exit");
	sleep_mask_a: assert property (o_sleeping |=> (o_ack & 7'h6f) == 7'h00) else $error("vector while asleep");
	disp_read_a: assert property (disp_take |=> o_rd_valid && o_rd_data == 4'h0) else $error("display read");
	io_read_a: assert property (io_take |=> (o_io_re && o_io_addr == $past(i_addr)) ##1 o_rd_valid)
		else $error("i/o read timing");
endmodule
bind interrupt_vector_and_memory_map ivmm_chk i_ivmm_chk (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_req(i_req),
	.i_int_enable(i_int_enable), .i_boundary(i_boundary), .i_re(i_re), .i_we(i_we), .i_addr(i_addr),
	.i_mreg_acc(i_mreg_acc), .o_pc_load(o_pc_load), .o_program_page_counter(o_program_page_counter),
	.o_program_step_counter(o_program_step_counter), .o_ack(o_ack), .o_vec_hold(o_vec_hold), .o_busy(o_busy),
	.o_sleeping(o_sleeping), .o_stack_pointer(o_stack_pointer), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
	.o_io_re(o_io_re), .o_io_addr(o_io_addr));

// >>> test/tb.sv
// testbench: vectors, priority, sleep, stack and data decode
// assumes io_peer answers i/o reads
`timescale 1ns/1ps
module tb;
	import ivmm_pkg::*;
	logic clk = 0, rst_b = 0, en = 1, bnd = 0, slp = 0, call = 0, pop = 0, acc = 0, we = 0, re = 0, pwe = 0;
	logic ld, sl, rv, dwe, iwe, ire, v, msl = 0;
	src_vec_t req = 7'h00, ack;
	page_t rp = 4'h0, pg;
	step_t rs = 8'h00, st;
	data_addr_t a = 10'h000, da, ia, x;
	nibble_t wd = 4'h0, iod, rdo, dw, iw, mp, d, y;
	ram_idx_t sp;
	int mismatches = 0, checked = 0, seed = 34, msp = 0;
	int mram[512];
	always #20 clk = ~clk;
	interrupt_vector_and_memory_map i_interrupt_vector_and_memory_map (.i_ref_clk(clk), .i_rst_b(rst_b),
		.i_req(req), .i_int_enable(en), .i_boundary(bnd), .i_sleep_req(slp), .i_call(call), .i_pop(pop),
		.i_ret_page(rp), .i_ret_step(rs), .i_addr(a), .i_mreg_acc(acc), .i_we(we), .i_re(re), .i_wdata(wd),
		.i_mreg_ptr_we(pwe), .i_io_rdata(iod), .o_pc_load(ld), .o_program_page_counter(pg),
		.o_program_step_counter(st), .o_ack(ack), .o_vec_hold(), .o_busy(), .o_sleeping(sl),
		.o_stack_pointer(sp), .o_memory_register_pointer(mp), .o_rd_data(rdo), .o_rd_valid(rv),
		.o_disp_we(dwe), .o_disp_addr(da), .o_disp_wdata(dw), .o_io_we(iwe), .o_io_re(ire), .o_io_addr(ia),
		.o_io_wdata(iw));
	io_peer i_io_peer (.i_ref_clk(clk), .i_io_re(ire), .i_io_addr(ia), .o_io_rdata(iod));
	task chk(input logic [15:0] g, input logic [15:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	function data_addr_t adr(input logic [8:0] i);
		return {i[8:7], 1'b0, i[6:0]};
	endfunction
	task wr(input data_addr_t ad, input nibble_t wv);
		@(negedge clk);
		a = ad;
		wd = wv;
		we = 1;
		@(negedge clk);
		we = 0;
	endtask
	task rd(input data_addr_t ad);
		@(negedge clk);
		a = ad;
		re = 1;
		@(negedge clk);
		re = 0;
		if (!rv) @(negedge clk);
		v = rv;
		d = rdo;
	endtask
	task push;
		msp = (msp - 3) & 511;
		mram[(msp + 2) & 511] = 32'(rp);
		mram[(msp + 1) & 511] = 32'(rs[7:4]);
		mram[msp] = 32'(rs[3:0]);
		chk(16'(sp), 16'(msp));
		for (int j = 0; j < 3; j++) begin
			rd(adr(9'((msp + j) & 511)));
			chk({v, d}, {1'b1, 4'(mram[(msp + j) & 511])});
		end
	endtask
	task entry(input src_vec_t q);
		int t;
		t = -1;
		for (int k = 0; k < 7; k++)
			if (q[k] && en && (!msl || k == 4)) t = k;
		@(negedge clk);
		req = q;
		bnd = 1;
		rp = 4'($random(seed));
		rs = 8'($random(seed));
		@(negedge clk);
		chk(16'(ack), t < 0 ? 16'h0000 : 16'(1 << t));
		req = req & ~ack;
		// boundary left high through the push: a busy block must not take again
		repeat (6) if (!ld) @(negedge clk);
		bnd = 0;
		if (t >= 0) begin
			chk({ld, pg, st}, {1'b1, 4'h1, 8'(2 + 2 * t)});
			push;
		end
		if (q[4]) msl = 0;
		req = 7'h00;
	endtask
	initial begin
		#160000;
		mismatches++;
		give_verdict;
	end
	initial begin
		repeat (12) @(negedge clk);
		rst_b = 1;
		@(negedge clk);
		chk({ld, pg, st}, {1'b1, 4'h1, 8'h00});
		for (int k = 0; k < 7; k++) entry(7'h01 << k);
		repeat (6) entry(7'($random(seed)));
		en = 0;
		entry(7'h41);
		en = 1;
		$display("vector tests done");
		@(negedge clk);
		call = 1;
		@(negedge clk);
		call = 0;
		repeat (4) @(negedge clk);
		push;
		@(negedge clk);
		pop = 1;
		@(negedge clk);
		pop = 0;
		msp = (msp + 3) & 511;
		chk(16'(sp), 16'(msp));
		@(negedge clk);
		slp = 1;
		@(negedge clk);
		slp = 0;
		msl = 1;
		chk(16'(sl), 16'h0001);
		entry(7'h6f);
		chk(16'(sl), 16'h0001);
		entry(7'h50);
		chk(16'(sl), 16'h0000);
		$display("stack and sleep tests done");
		repeat (8) begin
			x = 10'($random(seed)) & 10'h37f;
			y = 4'($random(seed));
			wr(x, y);
			rd(x);
			chk({v, d}, {1'b1, y});
		end
		@(negedge clk);
		wd = 4'h9;
		pwe = 1;
		@(negedge clk);
		pwe = 0;
		chk(16'(mp), 16'h0009);
		acc = 1;
		wr(10'h3ff, 4'h6);
		acc = 0;
		rd(10'h009);
		chk({v, d}, 16'h0016);
		acc = 1;
		rd(10'h3ff);
		acc = 0;
		chk({v, d}, 16'h0016);
		for (int k = 0; k < 4; k++) begin
			x = k == 0 ? 10'h18c : k == 1 ? 10'h293 : k == 2 ? 10'h3f7 : 10'h0c0;
			wr(x, 4'ha);
			if (k < 2) chk({dwe, da, dw}, {1'b1, x, 4'ha});
			else chk({iwe, ia, iw}, {1'b1, x, 4'ha});
			rd(x);
			chk({v, d}, {1'b1, k < 2 ? 4'h0 : x[3:0] ^ x[7:4]});
		end
		$display("data tests done");
		@(negedge clk);
		slp = 1;
		@(negedge clk);
		slp = 0;
		chk(16'(sl), 16'h0001);
		@(negedge clk);
		rst_b = 0;
		repeat (3) @(negedge clk);
		rst_b = 1;
		msp = 0;
		msl = 0;
		@(negedge clk);
		chk({ld, pg, st}, {1'b1, 4'h1, 8'h00});
		chk({sl, sp}, 16'h0000);
		$display("reset test done");
		give_verdict;
	end
endmodule
